/* inc/bus_transceiver_cfg.svh */
// Constants for the registered bus transceiver: widths, offsets, reset values.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef BUS_TRANSCEIVER_CFG_SVH
`define BUS_TRANSCEIVER_CFG_SVH

`define XCVR_DATA_WIDTH      18
`define XCVR_PIPE_FIRST_CNT  3
`define XCVR_SYNC_STAGES     2
`define XCVR_ADDR_WIDTH      4
`define XCVR_REG_WIDTH       32

`define XCVR_OFF_CTRL        4'h0
`define XCVR_OFF_A_TO_B_DATA 4'h4
`define XCVR_OFF_B_TO_A_DATA 4'h8
`define XCVR_OFF_STATUS      4'hc

`define XCVR_CTRL_A_ALLOW    0
`define XCVR_CTRL_B_ALLOW    1
`define XCVR_CTRL_RESET      2'h3

// Idle control pin levels held in the synchronisers during reset: both
// output enables high, every clock low
`define XCVR_CTL_IDLE        8'h22

`endif

/* inc/bus_transceiver_pkg.sv */
// Types shared by the registered bus transceiver and its bench.
// Assumes the constants header is on the include path.
`include "bus_transceiver_cfg.svh"

package bus_transceiver_pkg;

    // Control pins as they arrive from the outside buses
    typedef struct packed {
        logic a_to_b_clock;
        logic a_to_b_clock_enable_n;
        logic a_to_b_output_enable_n;
        logic b_to_a_first_stage_clock;
        logic b_to_a_final_stage_clock;
        logic b_to_a_clock_enable_n;
        logic b_to_a_output_enable_n;
        logic b_to_a_path_select_n;
    } ctl_pins_s;

    typedef logic [`XCVR_DATA_WIDTH-1:0] xcvr_data_t;

endpackage : bus_transceiver_pkg

/* rtl/registered_bus_transceiver_18b.sv */
// Holds the whole transceiver. The bus clocks and controls arrive as pins and are
// sampled on clk_sys_in, so each must stay high and low for at least one
// system clock for an edge to be seen.
`timescale 1ns/100ps
`include "bus_transceiver_cfg.svh"

module registered_bus_transceiver_18b #(
    parameter int DATA_WIDTH = `XCVR_DATA_WIDTH,
    parameter int FIRST_CNT  = `XCVR_PIPE_FIRST_CNT
) (
    input  wire logic                            clk_sys_in,
    input  wire logic                            rst_in,
    input  wire logic                            ce_in,
    input  wire bus_transceiver_pkg::ctl_pins_s  ctl_in,
    input  wire logic [DATA_WIDTH-1:0]           a_in,
    output logic      [DATA_WIDTH-1:0]           a_out,
    output logic                                 a_oe_out,
    input  wire logic [DATA_WIDTH-1:0]           b_in,
    output logic      [DATA_WIDTH-1:0]           b_out,
    output logic                                 b_oe_out,
    input  wire logic [`XCVR_ADDR_WIDTH-1:0]     addr_in,
    input  wire logic [`XCVR_REG_WIDTH-1:0]      wdata_in,
    input  wire logic                            wr_in,
    input  wire logic                            rd_in,
    output logic      [`XCVR_REG_WIDTH-1:0]      rdata_out
);

    localparam int CTL_W = $bits(bus_transceiver_pkg::ctl_pins_s);

    // Synchronisers: the first stage of each is read by its second stage only
    bus_transceiver_pkg::ctl_pins_s      ctl_meta;
    bus_transceiver_pkg::ctl_pins_s      ctl;
    logic [DATA_WIDTH-1:0]               a_meta;
    logic [DATA_WIDTH-1:0]               a_pin;
    logic [DATA_WIDTH-1:0]               b_meta;
    logic [DATA_WIDTH-1:0]               b_pin;

    // Edge history of the three bus clocks and the capture strobes
    logic [2:0]                          clk_prev;
    logic                                a_to_b_rise;
    logic                                first_rise;
    logic                                final_rise;
    logic                                a_to_b_take;
    logic                                first_take;
    logic                                final_take;

    // Data storage
    logic [DATA_WIDTH-1:0]               a_to_b_reg;
    logic [DATA_WIDTH-1:0]               pipe [0:FIRST_CNT-1];
    logic [DATA_WIDTH-1:0]               b_to_a_reg;
    logic [DATA_WIDTH-1:0]               next_b_to_a;

    // Software side
    logic [1:0]                          ctrl;
    logic [`XCVR_REG_WIDTH-1:0]          next_rdata;

    // Control pins. Reset loads the idle levels rather than zeros: zeros
    // would read as both output enables asserted and drive the ports
    // while the real pin levels are still on their way in.
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctl_meta <= `XCVR_CTL_IDLE;
            ctl      <= `XCVR_CTL_IDLE;
        end
        else if (ce_in)
        begin
            ctl_meta <= ctl_in;
            ctl      <= ctl_meta;
        end
    end

    // Port A data levels
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            a_meta <= '0;
            a_pin  <= '0;
        end
        else if (ce_in)
        begin
            a_meta <= a_in;
            a_pin  <= a_meta;
        end
    end

    // Port B data levels
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            b_meta <= '0;
            b_pin  <= '0;
        end
        else if (ce_in)
        begin
            b_meta <= b_in;
            b_pin  <= b_meta;
        end
    end

    // Edge detection looks only at the settled stage. The history resets to
    // the idle clock level, so no false edge follows reset.
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            clk_prev <= '0;
        end
        else if (ce_in)
        begin
            clk_prev <= {ctl.a_to_b_clock,
                         ctl.b_to_a_first_stage_clock,
                         ctl.b_to_a_final_stage_clock};
        end
    end

    assign a_to_b_rise = ctl.a_to_b_clock & ~clk_prev[2];
    assign first_rise  = ctl.b_to_a_first_stage_clock & ~clk_prev[1];
    assign final_rise  = ctl.b_to_a_final_stage_clock & ~clk_prev[0];

    // A clock edge counts only while its direction's enable is low
    assign a_to_b_take = ce_in & a_to_b_rise & ~ctl.a_to_b_clock_enable_n;
    assign first_take  = ce_in & first_rise & ~ctl.b_to_a_clock_enable_n;
    assign final_take  = ce_in & final_rise & ~ctl.b_to_a_clock_enable_n;

    // Single A to B register
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            a_to_b_reg <= '0;
        end
        else if (a_to_b_take)
        begin
            a_to_b_reg <= a_pin;
        end
    end

    // First three pipeline stages share the first-stage clock; the head
    // takes port B, every later stage takes the one before it
    genvar stage;
    generate
        for (stage = 0; stage < FIRST_CNT; stage++)
        begin : g_pipe
            if (stage == 0)
            begin : g_head
                always_ff @(posedge clk_sys_in or posedge rst_in)
                begin
                    if (rst_in)
                    begin
                        pipe[stage] <= '0;
                    end
                    else if (first_take)
                    begin
                        pipe[stage] <= b_pin;
                    end
                end
            end
            else
            begin : g_tail
                always_ff @(posedge clk_sys_in or posedge rst_in)
                begin
                    if (rst_in)
                    begin
                        pipe[stage] <= '0;
                    end
                    else if (first_take)
                    begin
                        pipe[stage] <= pipe[stage-1];
                    end
                end
            end
        end
    endgenerate

    // Select is sampled at the final-stage edge; low routes the pipeline tail.
    // When both edges land together the final stage takes the old tail.
    always_comb
    begin
        if (ctl.b_to_a_path_select_n)
        begin
            next_b_to_a = b_pin;
        end
        else
        begin
            next_b_to_a = pipe[FIRST_CNT-1];
        end
    end

    // Final B to A stage, the fourth stage in pipelined mode
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            b_to_a_reg <= '0;
        end
        else if (final_take)
        begin
            b_to_a_reg <= next_b_to_a;
        end
    end

    // Software may withhold either driver; it never touches the data registers
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl <= `XCVR_CTRL_RESET;
        end
        else if (ce_in && wr_in && addr_in == `XCVR_OFF_CTRL)
        begin
            ctrl <= wdata_in[1:0];
        end
    end

    // Readback mux; unmapped offsets read as zero
    always_comb
    begin
        next_rdata = '0;
        unique case (addr_in)
            `XCVR_OFF_CTRL:        next_rdata[1:0] = ctrl;
            `XCVR_OFF_A_TO_B_DATA: next_rdata[DATA_WIDTH-1:0] = a_to_b_reg;
            `XCVR_OFF_B_TO_A_DATA: next_rdata[DATA_WIDTH-1:0] = b_to_a_reg;
            `XCVR_OFF_STATUS:      next_rdata[CTL_W-1:0] = ctl;
            default:               next_rdata = '0;
        endcase
    end

    // While ce_in is high read data stand only in the cycle after each cycle of rd_in, so a stale word is never mistaken
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_out <= '0;
        end
        else if (ce_in)
        begin
            rdata_out <= rd_in ? next_rdata : '0;
        end
    end

    // Data stay in flops; only the enables release the ports
    assign b_out    = a_to_b_reg;
    assign a_out    = b_to_a_reg;
    assign b_oe_out = ~ctl.a_to_b_output_enable_n & ctrl[`XCVR_CTRL_A_ALLOW];
    assign a_oe_out = ~ctl.b_to_a_output_enable_n & ctrl[`XCVR_CTRL_B_ALLOW];

endmodule : registered_bus_transceiver_18b

/* test/bus_side_model.sv */
// Far-side bus logic: drives port data levels and the control pins.
// Assumes the bench resolves each shared port from the device's output enable.
`timescale 1ns/100ps
`include "bus_transceiver_cfg.svh"
module bus_side_model (
    input  wire logic                           clk_sys_in,
    output bus_transceiver_pkg::ctl_pins_s      ctl_out,
    output logic [`XCVR_DATA_WIDTH-1:0]         a_drv_out,
    output logic [`XCVR_DATA_WIDTH-1:0]         b_drv_out
);
    initial
    begin
        ctl_out = 8'h03;
        a_drv_out = '0;
        b_drv_out = '0;
    end
    task pin(input int i, input logic v);
        @(posedge clk_sys_in);
        ctl_out[i] <= v;
    endtask : pin
    // Pins are sampled: each level is held five system clocks so no edge is lost
    task pulse(input int i);
        pin(i, 1'b1);
        repeat (4) @(posedge clk_sys_in);
        pin(i, 1'b0);
        repeat (4) @(posedge clk_sys_in);
    endtask : pulse
    task drive(input logic [`XCVR_DATA_WIDTH-1:0] a, b);
        @(posedge clk_sys_in);
        a_drv_out <= a;
        b_drv_out <= b;
    endtask : drive
endmodule : bus_side_model

/* test/xcvr_checker.sv */
// Port checker for the transceiver, bound to its top module.
// Assumes pin levels last at least four system clocks.
`timescale 1ns/100ps
`include "bus_transceiver_cfg.svh"
module xcvr_checker #(
    parameter int DATA_WIDTH = `XCVR_DATA_WIDTH
) (
    input wire logic                           clk_sys_in,
    input wire logic                           rst_in,
    input wire bus_transceiver_pkg::ctl_pins_s ctl_in,
    input wire logic [DATA_WIDTH-1:0]          a_in,
    input wire logic [DATA_WIDTH-1:0]          a_out,
    input wire logic                           a_oe_out,
    input wire logic [DATA_WIDTH-1:0]          b_out,
    input wire logic                           b_oe_out,
    input wire logic                           rd_in,
    input wire logic [`XCVR_REG_WIDTH-1:0]     rdata_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    hold_ab_a: assert property (ctl_in.a_to_b_clock_enable_n [*5] |-> $stable(b_out))
        else $error("b_out moved while held");
    hold_ba_a: assert property (ctl_in.b_to_a_clock_enable_n [*5] |-> $stable(a_out))
        else $error("a_out moved while held");
    quiet_ab_a: assert property (!ctl_in.a_to_b_clock [*6] |-> $stable(b_out))
        else $error("b_out moved without its clock");
    quiet_ba_a: assert property (!ctl_in.b_to_a_final_stage_clock [*6] |-> $stable(a_out))
        else $error("a_out moved without final clock");
    off_a_a: assert property (ctl_in.b_to_a_output_enable_n [*4] |-> !a_oe_out)
        else $error("A driven while disabled");
    off_b_a: assert property (ctl_in.a_to_b_output_enable_n [*4] |-> !b_oe_out)
        else $error("B driven while disabled");
    ab_data_a: assert property ($changed(b_out) |-> b_out == $past(a_in, 3))
        else $error("b_out not from port A");
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0)
        else $error("read data outside its cycle");
    cover property (ctl_in.a_to_b_clock_enable_n [*5]);
    cover property ($changed(a_out));
    cover property (a_oe_out ##1 !a_oe_out);
endmodule : xcvr_checker

bind registered_bus_transceiver_18b xcvr_checker #(.DATA_WIDTH(DATA_WIDTH)) u_chk (
    .clk_sys_in, .rst_in, .ctl_in, .a_in, .a_out, .a_oe_out, .b_out, .b_oe_out,
    .rd_in, .rdata_out);

/* test/tb_top.sv */
// Bench top: transceiver, far-side model, register-port tasks and checks.
// Assumes package, model and checker files are compiled before it.
`timescale 1ns/100ps
module tb_top;
    logic        clk_sys_in, rst_in, ce_in, wr_in, rd_in, a_oe_out, b_oe_out;
    logic [3:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, rd_val;
    logic [17:0] a_pin, b_pin, a_out, b_out, a_drv, b_drv;
    bus_transceiver_pkg::ctl_pins_s ctl;
    int          n_mismatch = 0;
    int          tests_run = 0;
    // Shared ports: the device wins while it drives, else the far side shows
    assign a_pin = a_oe_out ? a_out : a_drv;
    assign b_pin = b_oe_out ? b_out : b_drv;
    registered_bus_transceiver_18b DUT (.clk_sys_in, .rst_in, .ce_in, .ctl_in(ctl),
        .a_in(a_pin), .a_out, .a_oe_out, .b_in(b_pin), .b_out, .b_oe_out,
        .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out);
    bus_side_model bfm (.clk_sys_in, .ctl_out(ctl), .a_drv_out(a_drv), .b_drv_out(b_drv));
    initial
    begin
        clk_sys_in = 0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task chk(input logic [17:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [3:0] a);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 rd_val = rdata_out;
    endtask : rd
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr
    task conclude;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (3000) @(posedge clk_sys_in);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        {rst_in, ce_in, wr_in, rd_in, addr_in, wdata_in} = {2'b11, 38'h0};
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        bfm.drive(18'h2a5a5, 18'h3c3c3);
        bfm.pulse(7);
        chk(b_out, 18'h2a5a5);
        chk(18'(b_oe_out), 18'h1);
        rd(4'h4);
        chk(rd_val[17:0], 18'h2a5a5);
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        bfm.drive(18'h15a5a, 18'h3c3c3);
        bfm.pulse(7);
        @(posedge clk_sys_in);
        ce_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        chk(b_out, 18'h2a5a5);
        bfm.pin(6, 1'b1);
        bfm.drive(18'h15a5a, 18'h3c3c3);
        bfm.pulse(7);
        chk(b_out, 18'h2a5a5);
        bfm.pin(5, 1'b1);
        bfm.pin(1, 1'b0);
        bfm.pulse(3);
        chk(a_out, 18'h3c3c3);
        chk({16'h0, a_oe_out, b_oe_out}, 18'h2);
        bfm.pin(0, 1'b0);
        for (int i = 1; i < 4; i++)
        begin
            bfm.drive(18'h15a5a, 18'(18'h11111 * i));
            bfm.pulse(4);
        end
        chk(a_out, 18'h3c3c3);
        bfm.pulse(3);
        chk(a_out, 18'h11111);
        bfm.pin(2, 1'b1);
        bfm.pulse(4);
        bfm.pulse(3);
        chk(a_out, 18'h11111);
        bfm.pin(1, 1'b1);
        repeat (4) @(posedge clk_sys_in);
        chk(18'(a_oe_out), 18'h0);
        rd(4'h8);
        chk(rd_val[17:0], 18'h11111);
        rd(4'h2);
        chk(rd_val[17:0], 18'h0);
        wr(4'h0, 32'h0);
        bfm.pin(5, 1'b0);
        repeat (4) @(posedge clk_sys_in);
        chk(18'(b_oe_out), 18'h0);
        wr(4'h0, 32'h3);
        rd(4'h0);
        chk(rd_val[17:0], 18'h3);
        chk(18'(b_oe_out), 18'h1);
        rd(4'hc);
        chk(rd_val[17:0], 18'h46);
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        chk(a_out, 18'h0);
        chk(b_out, 18'h0);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        chk(18'(b_oe_out), 18'h1);
        rd(4'h0);
        chk(rd_val[17:0], 18'h3);
        conclude();
    end
endmodule : tb_top
